// >>> hdl/lbp_regs.sv
// Our own choice: strobed register access.
`timescale 1ns/1ps
// Behaviour
// - Prescaler amplitude codes 0..3 give 2/3, 1/2, 4/3, 1 of nominal swing
// - Receive LO buffer amplitude code 0 smallest load, 7 largest, monotonic
// - Transmit LO buffer amplitude code 0 smallest load, 7 largest
// - Prescaler bias codes 0..3 give 1, 2/3, 1/2, 2/5 of nominal current
// - Receive LO buffer bias code 0 minimum current, 7 maximum
// - Transmit LO buffer bias code 0 minimum current, 7 maximum
// - Eight-bit charge-pump scaling factor held, resets to 134
// - Writing start bit 0 then 1 while idle launches calibration; steady value does nothing
// - Dual-store set: results go to both slots A and B
// - Dual-store clear: results go only to slot picked by slot select
// - Wait codes 0..3 give 90000, 110000, 130000, 200000 reference periods
// - DAC start value is iteration code plus one; default code 5
module lbp_regs #(
  parameter int WAIT0 = lbp_pkg::CAL_WAIT0,
  parameter int WAIT1 = lbp_pkg::CAL_WAIT1,
  parameter int WAIT2 = lbp_pkg::CAL_WAIT2,
  parameter int WAIT3 = lbp_pkg::CAL_WAIT3
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  input  wire logic [lbp_pkg::AW-1:0] addr,
  input  wire logic [lbp_pkg::DW-1:0] wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  input  wire logic                   slot_sel,
  output logic      [lbp_pkg::DW-1:0] rdata,
  output lbp_pkg::lbp_lo_s            lo_cfg,
  output logic      [lbp_pkg::DW-1:0] loop_bandwidth_scale,
  output logic                        cal_busy,
  output logic      [3:0]             dac_start,
  output logic                        store_a,
  output logic                        store_b
);

  localparam int CW = lbp_pkg::CAL_CW;

  // Counter must hold every wait count; busy must last two cycles at least
  if (WAIT0 < 2 || WAIT1 < 2 || WAIT2 < 2 || WAIT3 < 2 ||
      WAIT0 >= 2**CW || WAIT1 >= 2**CW || WAIT2 >= 2**CW || WAIT3 >= 2**CW) begin : g_chk
    $error("Calibration wait count out of range");
  end

  // Reset release synchroniser
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // Register storage
  logic [lbp_pkg::DW-1:0] amp_r;
  logic [lbp_pkg::DW-1:0] bias_r;
  logic [lbp_pkg::DW-1:0] bw_r;
  logic [lbp_pkg::DW-1:0] cal_r;
  logic [lbp_pkg::DW-1:0] cal_nxt;

  // Address decode
  wire sel_amp  = addr == lbp_pkg::OFS_AMP;
  wire sel_bias = addr == lbp_pkg::OFS_BIAS;
  wire sel_bw   = addr == lbp_pkg::OFS_BW;
  wire sel_cal  = addr == lbp_pkg::OFS_CAL;
  wire sel_stat = addr == lbp_pkg::OFS_STAT;

  wire wr_amp  = wr && sel_amp;
  wire wr_bias = wr && sel_bias;
  wire wr_bw   = wr && sel_bw;
  wire wr_cal  = wr && sel_cal;

  // Reserved bit is not stored
  assign cal_nxt = wdata & ~(8'h01 << lbp_pkg::F_RSV);

  // Field views
  wire [1:0] pre_amp  = amp_r[lbp_pkg::F_PRE+:2];
  wire [2:0] rx_amp   = amp_r[lbp_pkg::F_RX+:3];
  wire [2:0] tx_amp   = amp_r[lbp_pkg::F_TX+:3];
  wire [1:0] pre_bias = bias_r[lbp_pkg::F_PRE+:2];
  wire [2:0] rx_bias  = bias_r[lbp_pkg::F_RX+:3];
  wire [2:0] tx_bias  = bias_r[lbp_pkg::F_TX+:3];
  wire       dual     = cal_r[lbp_pkg::F_DUAL];

  // Software register writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      amp_r  <= lbp_pkg::RST_AMP;
      bias_r <= lbp_pkg::RST_BIAS;
      bw_r   <= lbp_pkg::RST_BW;
      cal_r  <= lbp_pkg::RST_CAL;
    end else begin
      if (wr_amp)  amp_r  <= wdata;
      if (wr_bias) bias_r <= wdata;
      if (wr_bw)   bw_r   <= wdata;
      if (wr_cal)  cal_r  <= cal_nxt;
    end
  end

  // Prescaler swing in twelfths of nominal
  logic [4:0] pre_swing_nxt;
  always_comb begin
    case (pre_amp)
      2'h0:    pre_swing_nxt = 5'h08;
      2'h1:    pre_swing_nxt = 5'h06;
      2'h2:    pre_swing_nxt = 5'h10;
      default: pre_swing_nxt = 5'h0c;
    endcase
  end

  // Prescaler current in thirtieths of nominal
  logic [4:0] pre_bias_nxt;
  always_comb begin
    case (pre_bias)
      2'h0:    pre_bias_nxt = 5'h1e;
      2'h1:    pre_bias_nxt = 5'h14;
      2'h2:    pre_bias_nxt = 5'h0f;
      default: pre_bias_nxt = 5'h0c;
    endcase
  end

  // Thermometer steps: more code, more load or current
  function automatic logic [6:0] thermo(input logic [2:0] code);
    thermo = ~(7'h7f << code);
  endfunction

  lbp_pkg::lbp_lo_s lo_nxt;
  // One driver for the whole decoded word, fields in struct order
  assign lo_nxt = {pre_swing_nxt,
                   thermo(rx_amp),
                   thermo(tx_amp),
                   pre_bias_nxt,
                   thermo(rx_bias),
                   thermo(tx_bias)};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) lo_cfg <= '0;
    else        lo_cfg <= lo_nxt;
  end

  assign loop_bandwidth_scale = bw_r;

  // Start only on a written 0-to-1 change of the start bit
  wire start_pulse = wr_cal && wdata[lbp_pkg::F_START] && !cal_r[lbp_pkg::F_START];

  // Wait count of the selected code
  logic [CW-1:0] tgt_nxt;
  always_comb begin
    case (wdata[lbp_pkg::F_WAIT+:2])
      2'h0:    tgt_nxt = CW'(WAIT0);
      2'h1:    tgt_nxt = CW'(WAIT1);
      2'h2:    tgt_nxt = CW'(WAIT2);
      default: tgt_nxt = CW'(WAIT3);
    endcase
  end

  // Calibration sequencer
  lbp_pkg::lbp_state_e st_r;
  logic [CW-1:0]       cnt_r;
  logic [CW-1:0]       tgt_r;
  wire                 last = cnt_r == tgt_r - CW'(1);
  wire                 done = st_r == lbp_pkg::LBP_RUN && last;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= lbp_pkg::LBP_IDLE;
      cnt_r     <= '0;
      tgt_r     <= CW'(WAIT0);
      dac_start <= {1'b0, lbp_pkg::RST_CAL[lbp_pkg::F_ITER+:3]} + 4'h1;
      store_a   <= 1'b0;
      store_b   <= 1'b0;
    end else begin
      store_a <= 1'b0;
      store_b <= 1'b0;
      case (st_r)
        lbp_pkg::LBP_IDLE: begin
          if (start_pulse) begin
            st_r      <= lbp_pkg::LBP_RUN;
            cnt_r     <= '0;
            tgt_r     <= tgt_nxt;
            dac_start <= {1'b0, wdata[lbp_pkg::F_ITER+:3]} + 4'h1;
          end
        end
        lbp_pkg::LBP_RUN: begin
          cnt_r <= cnt_r + CW'(1);
          if (last) begin
            st_r    <= lbp_pkg::LBP_IDLE;
            store_a <= dual || !slot_sel;
            store_b <= dual || slot_sel;
          end
        end
        default: st_r <= lbp_pkg::LBP_IDLE;
      endcase
    end
  end

  // Busy flag from a flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cal_busy <= 1'b0;
    else if (start_pulse && st_r == lbp_pkg::LBP_IDLE) cal_busy <= 1'b1;
    else if (done) cal_busy <= 1'b0;
  end

  // Read mux; unmapped addresses read zero
  logic [lbp_pkg::DW-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (sel_amp)  rd_mux = amp_r;
    if (sel_bias) rd_mux = bias_r;
    if (sel_bw)   rd_mux = bw_r;
    if (sel_cal)  rd_mux = cal_r;
    if (sel_stat) rd_mux[lbp_pkg::F_BUSY] = cal_busy;
  end

  // Read data stands for one cycle only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)  rdata <= '0;
    else if (rd) rdata <= rd_mux;
    else         rdata <= '0;
  end

  // Checks on decoded settings, register writes and calibration
  chk_pre_amp: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pre_amp == 2'h2 |=> lo_cfg.pre_swing_12th == 5'h10)
    else $error("Prescaler swing code 2 not 4/3");

  chk_rx_amp: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rx_amp == 3'h7 |=> lo_cfg.rx_swing_th == 7'h7f)
    else $error("Rx swing code 7 not largest");

  chk_tx_amp: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tx_amp == 3'h0 |=> lo_cfg.tx_swing_th == 7'h00)
    else $error("Tx swing code 0 not smallest");

  chk_pre_bias: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pre_bias == 2'h3 |=> lo_cfg.pre_bias_30th == 5'h0c)
    else $error("Prescaler current code 3 not 2/5");

  chk_rx_bias_mono: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rx_bias) < rx_bias |=> $past(lo_cfg.rx_bias_th) < lo_cfg.rx_bias_th)
    else $error("Rx bias not monotonic");

  chk_tx_bias: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tx_bias == 3'h4 |=> lo_cfg.tx_bias_th == 7'h0f)
    else $error("Tx bias code 4 wrong");

  chk_bw_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_bw |=> loop_bandwidth_scale == $past(wdata))
    else $error("Bandwidth scale write lost");

  chk_start_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !cal_busy && !start_pulse |=> !cal_busy)
    else $error("Calibration began without a start edge");

  chk_start_go: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start_pulse && !cal_busy |=> cal_busy [*2])
    else $error("Start edge did not launch calibration");

  chk_dual_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done && dual |=> store_a && store_b)
    else $error("Dual store missed a slot");

  chk_single_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done && !dual |=> store_a == !$past(slot_sel) && store_b == $past(slot_sel))
    else $error("Single store hit wrong slot");

  chk_wait_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start_pulse && !cal_busy && wdata[lbp_pkg::F_WAIT+:2] == 2'h3 |=> tgt_r == CW'(WAIT3))
    else $error("Wait code 3 count wrong");

  chk_dac_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start_pulse && !cal_busy |=> dac_start == {1'b0, $past(wdata[2:0])} + 4'h1)
    else $error("DAC start value not code plus one");

  chk_no_early: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (store_a || store_b) |-> $past(cnt_r) == tgt_r - CW'(1))
    else $error("Results stored before wait elapsed");

  // Busy length counted apart from the sequencer counter
  logic [CW-1:0] busy_len_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)        busy_len_r <= '0;
    else if (cal_busy) busy_len_r <= busy_len_r + CW'(1);
    else               busy_len_r <= '0;
  end

  chk_busy_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (store_a || store_b) |-> busy_len_r == tgt_r)
    else $error("Calibration length differs from wait count");

  chk_busy_ignore: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start_pulse && cal_busy |=> dac_start == $past(dac_start))
    else $error("Start edge during calibration was not ignored");

  chk_stat_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd && sel_stat |=> rdata == {7'h00, $past(cal_busy)})
    else $error("Status read does not show busy");

endmodule // lbp_regs

// >>> hdl/lbp_pkg.sv
package lbp_pkg;

  // Register bus widths
  localparam int AW = 8;
  localparam int DW = 8;

  // Register offsets
  localparam logic [AW-1:0] OFS_AMP  = 8'h18;
  localparam logic [AW-1:0] OFS_BIAS = 8'h19;
  localparam logic [AW-1:0] OFS_BW   = 8'h1a;
  localparam logic [AW-1:0] OFS_CAL  = 8'h1b;
  localparam logic [AW-1:0] OFS_STAT = 8'h3f;

  // Reset values
  localparam logic [DW-1:0] RST_AMP  = 8'he1;
  localparam logic [DW-1:0] RST_BIAS = 8'h65;
  localparam logic [DW-1:0] RST_BW   = 8'h86;
  localparam logic [DW-1:0] RST_CAL  = 8'h05;

  // Field positions (low bit of each field)
  localparam int F_PRE   = 6;
  localparam int F_RX    = 3;
  localparam int F_TX    = 0;
  localparam int F_START = 7;
  localparam int F_DUAL  = 6;
  localparam int F_WAIT  = 4;
  localparam int F_RSV   = 3;
  localparam int F_ITER  = 0;
  localparam int F_BUSY  = 0;

  // Calibration durations in reference clock periods
  localparam int CAL_WAIT0 = 90000;
  localparam int CAL_WAIT1 = 110000;
  localparam int CAL_WAIT2 = 130000;
  localparam int CAL_WAIT3 = 200000;
  localparam int CAL_CW    = 18;

  // Calibration sequencer states
  typedef enum logic [0:0] {
    LBP_IDLE = 1'b0,
    LBP_RUN  = 1'b1
  } lbp_state_e;

  // Decoded LO and prescaler settings
  typedef struct packed {
    logic [4:0] pre_swing_12th;
    logic [6:0] rx_swing_th;
    logic [6:0] tx_swing_th;
    logic [4:0] pre_bias_30th;
    logic [6:0] rx_bias_th;
    logic [6:0] tx_bias_th;
  } lbp_lo_s;

endpackage

// >>> sim/lbp_host.sv
`timescale 1ns/1ps
// Host side of the register port; released lines show inverted values
module lbp_host (
  input  wire logic       ref_clk,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd
);
  logic [7:0] q[$];
  // Recommended lower band settings; scale value for a 25 MHz reference
  localparam logic [7:0] REC_AMP  = 8'h14;
  localparam logic [7:0] REC_BIAS = 8'h22;
  localparam logic [7:0] REC_BW   = 8'hcb;
  // Quiet bus at time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One strobe cycle; entered just after a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge ref_clk);
  endtask
  // Release strobes and scramble the lines
  task idle();
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= ~addr;
    wdata <= ~wdata;
    @(posedge ref_clk);
  endtask
  // Read with the expected byte noted first
  task rreg(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  // Rearm with zero, then raise start; reserved bit kept clear
  task cal_go(input logic [1:0] wt, input logic du, input logic [2:0] it);
    bus(1'b1, lbp_pkg::OFS_CAL, {1'b0, du, wt, 1'b0, it});
    bus(1'b1, lbp_pkg::OFS_CAL, {1'b1, du, wt, 1'b0, it});
    idle();
  endtask
endmodule // lbp_host

// >>> sim/lbp_regs_tb.sv
`timescale 1ns/1ps
module lbp_regs_tb;
  logic             ref_clk, rst_b, slot_sel, wr, rd, cal_busy, store_a, store_b, pend, du;
  logic [7:0]       addr, wdata, rdata, loop_bandwidth_scale;
  logic [3:0]       dac_start;
  logic [2:0]       it;
  lbp_pkg::lbp_lo_s lo_cfg;
  int               n_fail, n_compared, cnt;
  logic [9:0]       cq[$];
  int               W[4] = '{10, 12, 14, 20};
  logic [4:0]       SW[4] = '{5'd8, 5'd6, 5'd16, 5'd12};
  logic [4:0]       SB[4] = '{5'd30, 5'd20, 5'd15, 5'd12};

  lbp_regs #(.WAIT0(10), .WAIT1(12), .WAIT2(14), .WAIT3(20)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .slot_sel(slot_sel), .rdata(rdata), .lo_cfg(lo_cfg),
    .loop_bandwidth_scale(loop_bandwidth_scale), .cal_busy(cal_busy), .dac_start(dac_start), .store_a(store_a), .store_b(store_b));
  lbp_host u_host (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

  // Clock, 40 ns period
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  function automatic logic [6:0] th(input logic [2:0] c);
    return ~(7'h7f << c);
  endfunction
  task note(input logic ok, input string m);
    n_compared++;
    if (!ok) begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task cmp_rd(input logic [7:0] g, input logic [7:0] e);
    note(g === e, $sformatf("byte %h exp %h", g, e));
  endtask
  task cmp_cal(input logic [9:0] g, input logic [9:0] e);
    note(g === e, $sformatf("cal %h exp %h", g, e));
  endtask
  task cmp_lo(input lbp_pkg::lbp_lo_s g, input lbp_pkg::lbp_lo_s e);
    note(g === e, $sformatf("lo %h exp %h", g, e));
  endtask
  task final_report();
    if (u_host.q.size() != 0 || cq.size() != 0) n_fail++;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watches read data and store pulses against the noted results
  always @(posedge ref_clk) begin
    if (pend) cmp_rd(rdata, u_host.q.pop_front());
    else if (rst_b === 1'b1 && rdata !== 8'h00) cmp_rd(rdata, 8'h00);
    pend = rd;
    if (store_a || store_b) begin
      cmp_cal({store_a, store_b, cnt[7:0]}, cq.pop_front());
      cnt = 0;
    end else if (cal_busy) cnt++;
  end
  // Write both LO registers, read back, check decode
  task cfg(input logic [7:0] a, input logic [7:0] b);
    lbp_pkg::lbp_lo_s e;
    e = {SW[a[7:6]], th(a[5:3]), th(a[2:0]), SB[b[7:6]], th(b[5:3]), th(b[2:0])};
    u_host.bus(1'b1, lbp_pkg::OFS_AMP, a);
    u_host.bus(1'b1, lbp_pkg::OFS_BIAS, b);
    u_host.rreg(lbp_pkg::OFS_AMP, a);
    u_host.rreg(lbp_pkg::OFS_BIAS, b);
    u_host.idle();
    repeat (2) @(posedge ref_clk);
    cmp_lo(lo_cfg, e);
  endtask
  // Watchdog
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
  // Main sequence
  initial begin
    rst_b = 1'b0;
    slot_sel = 1'b0;
    pend = 1'b0;
    cnt = 0;
    n_fail = 0;
    n_compared = 0;
    void'($urandom(88481));
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cmp_rd(loop_bandwidth_scale, 8'h86);
    cmp_rd({4'h0, dac_start}, 8'h06);
    u_host.rreg(lbp_pkg::OFS_AMP, lbp_pkg::RST_AMP);
    u_host.rreg(lbp_pkg::OFS_BIAS, lbp_pkg::RST_BIAS);
    u_host.rreg(lbp_pkg::OFS_BW, lbp_pkg::RST_BW);
    u_host.rreg(lbp_pkg::OFS_CAL, lbp_pkg::RST_CAL);
    u_host.rreg(lbp_pkg::OFS_STAT, 8'h00);
    u_host.rreg(8'h20, 8'h00);
    u_host.idle();
    cmp_lo(lo_cfg, {SW[lbp_pkg::RST_AMP[7:6]], th(lbp_pkg::RST_AMP[5:3]), th(lbp_pkg::RST_AMP[2:0]),
                    SB[lbp_pkg::RST_BIAS[7:6]], th(lbp_pkg::RST_BIAS[5:3]), th(lbp_pkg::RST_BIAS[2:0])});
    $display("test reset done");
    for (int i = 0; i < 4; i++) cfg({i[1:0], 6'($urandom)}, {i[1:0], 6'($urandom)});
    cfg(8'h38, 8'h07);
    cfg(8'h07, 8'h38);
    cfg(8'h00, 8'h04);
    cfg(u_host.REC_AMP, u_host.REC_BIAS);
    u_host.bus(1'b1, lbp_pkg::OFS_BW, u_host.REC_BW);
    u_host.idle();
    cmp_rd(loop_bandwidth_scale, u_host.REC_BW);
    $display("test lo done");
    for (int k = 0; k < 4; k++) begin
      it = (k == 3) ? 3'd4 : 3'($urandom);
      du = k[0];
      slot_sel <= k[1];
      cq.push_back({du | !k[1], du | k[1], 8'(W[k])});
      u_host.cal_go(k[1:0], du, it);
      cmp_rd({4'h0, dac_start}, {5'h00, it} + 8'h01);
      u_host.rreg(lbp_pkg::OFS_STAT, 8'h01);
      u_host.idle();
      if (k == 2) u_host.cal_go(2'd2, 1'b0, 3'd7);
      for (int t = 0; t < 40 && cal_busy !== 1'b0; t++) @(posedge ref_clk);
      note(cal_busy === 1'b0, "calibration did not end");
      repeat (2) @(posedge ref_clk);
      cmp_rd({4'h0, dac_start}, {5'h00, it} + 8'h01);
      u_host.bus(1'b1, lbp_pkg::OFS_CAL, {1'b1, du, k[1:0], 1'b0, it});
      u_host.rreg(lbp_pkg::OFS_CAL, {1'b1, du, k[1:0], 1'b0, it});
      u_host.idle();
      repeat (3) @(posedge ref_clk);
      cmp_rd({7'h00, cal_busy}, 8'h00);
      $display("test cal %0d done", k);
    end
    final_report();
  end
endmodule // lbp_regs_tb
